// ==== ascp_pkg.sv ====
// shared constants and types of the ascii serial command port
package ascp_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int CLK_MHZ = CLK_HZ / 1_000_000;
	localparam int BAUD = 9600;
	localparam int BAUD_DIV_DEF = CLK_HZ / BAUD;
	// reply start windows, microseconds
	localparam int DLY_DOL_MIN_US = 50_000;
	localparam int DLY_DOL_MAX_US = 100_000;
	localparam int DLY_STAR_MIN_US = 2_000;
	localparam int DLY_STAR_MAX_US = 50_000;
	localparam int DLY_DOL_CYC = DLY_DOL_MIN_US * CLK_MHZ;
	localparam int DLY_STAR_CYC = DLY_STAR_MIN_US * CLK_MHZ;
	localparam int DATA_BITS = 8;
	localparam int HEX_DIGITS = 8;
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ODD = 2'h1;
	localparam logic [1:0] PAR_EVEN = 2'h2;
	localparam logic [3:0] NB_NOPAR = 4'hA;
	localparam logic [3:0] NB_PAR = 4'hB;
	localparam logic [7:0] CH_NUL = 8'h00;
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_DOLLAR = 8'h24;
	localparam logic [7:0] CH_STAR = 8'h2A;
	localparam logic [7:0] CH_MINUS = 8'h2D;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_9 = 8'h39;
	localparam logic [7:0] CH_AT = 8'h40;
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_R = 8'h52;
	localparam logic [7:0] CH_S = 8'h53;
	localparam logic [7:0] CH_T = 8'h54;
	localparam logic [7:0] CH_W = 8'h57;
	localparam logic [7:0] CH_LA = 8'h61;
	localparam logic [7:0] CH_LZ = 8'h7A;
	localparam logic [7:0] CASE_MASK = 8'hDF;
	localparam logic [15:0] TXT_ADDR = 16'h0014;
	// reply kinds
	localparam logic [1:0] REP_VAL = 2'h0;
	localparam logic [1:0] REP_ACK = 2'h1;
	localparam logic [1:0] REP_NUL = 2'h2;
	localparam logic [3:0] LEN_VAL = 4'hA;
	localparam logic [3:0] LEN_ACK = 4'h2;
	localparam logic [3:0] LEN_NUL = 4'h3;
	typedef enum logic [2:0] {
		P_IDLE = 3'h0,
		P_NODE = 3'h1,
		P_ADDR = 3'h2,
		P_DATA = 3'h3,
		P_FETCH = 3'h4,
		P_WAIT = 3'h5,
		P_SEND = 3'h6
	} ascp_pst_e;
endpackage : ascp_pkg

// ==== ascp_port.sv ====
// ascii serial command port: uart, command parser and timed reply
// Operation
// - frame opens with start bit, then data bits lsb first
// - parity none, odd or even, same setting at both ends
// - parity bit after data makes the ones count odd or even
// - parity comes from stored calibration setting, never from a command
// - exactly one stop bit ends every frame
// - after stop bit receiver hunts for next start edge and resyncs
// - half duplex: received characters dropped while a reply goes out
// - character time is ten bit periods over the baud rate, eleven with parity
// - read reply is value as ascii, then cr then lf
// - write performs update first, then replies cr lf only
// - dollar terminator: reply starts 50 to 100 ms later
// - asterisk terminator: reply starts 2 to 50 ms later
// - after last reply character next command is accepted at once
// - read without node or register address returns displayed value
// - digits after start pick node; case of letters ignored
// - text register write takes a character string as data
// - write: address, separator, decimal value, terminator
// - non digit after start means node zero, answered by all
// - bad command letter abandons the command
// - missing register answered with nul, cr, lf
`timescale 1ns/1ps
module ascp_port
	import ascp_pkg::*;
#(
	parameter int BAUD_DIV = BAUD_DIV_DEF,
	parameter int DLY_DOL = DLY_DOL_CYC,
	parameter int DLY_STAR = DLY_STAR_CYC
)(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic rxd,
	output logic txd,
	output logic tx_en,
	input wire logic [1:0] par_cfg,
	input wire logic [7:0] my_node,
	input wire logic [31:0] disp_value,
	output logic [15:0] reg_addr,
	output logic [31:0] reg_wdata,
	output logic reg_we,
	output logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_ok,
	output logic txt_valid,
	output logic [7:0] txt_char
);
	localparam int DW = $clog2(BAUD_DIV + 1);
	localparam int LW = $clog2(DLY_DOL + 1);

	typedef struct packed {
		ascp_pst_e pst;
		logic [1:0] par;
		logic s1;
		logic s2;
		logic s3;
		logic rx_busy;
		logic [3:0] rx_bit;
		logic [DW-1:0] rx_div;
		logic [7:0] rx_data;
		logic rx_pb;
		logic [7:0] node;
		logic is_wr;
		logic is_txt;
		logic has_addr;
		logic has_dig;
		logic neg;
		logic star;
		logic [15:0] addr;
		logic [31:0] mag;
		logic [31:0] wd;
		logic reg_we;
		logic reg_rd;
		logic txt_valid;
		logic [7:0] txt_char;
		logic [1:0] rep;
		logic [31:0] val;
		logic [LW-1:0] dly;
		logic [3:0] idx;
		logic tx_busy;
		logic [3:0] tx_bit;
		logic [DW-1:0] tx_div;
		logic [10:0] tx_sh;
		logic txd;
		logic de;
	} ascp_st_s;

	ascp_st_s q;
	ascp_st_s next_q;

	function automatic logic [3:0] ascp_rep_len(input logic [1:0] k);
		ascp_rep_len = (k == REP_VAL) ? LEN_VAL : ((k == REP_ACK) ? LEN_ACK : LEN_NUL);
	endfunction : ascp_rep_len

	// value goes out as fixed-width hex, most significant digit first
	function automatic logic [7:0] ascp_rep_char(input logic [1:0] k, input logic [3:0] i,
		input logic [31:0] v);
		logic [3:0] len;
		logic [4:0] b;
		logic [3:0] n;
		len = ascp_rep_len(k);
		b = {3'(3'h7 - i[2:0]), 2'b00};
		n = v[b +: 4];
		if (i == len - 4'h1)
			ascp_rep_char = CH_LF;
		else if (i == len - 4'h2)
			ascp_rep_char = CH_CR;
		else if (k == REP_NUL)
			ascp_rep_char = CH_NUL;
		else if (n < 4'hA)
			ascp_rep_char = CH_0 + {4'h0, n};
		else
			ascp_rep_char = CH_A + {4'h0, n} - 8'h0A;
	endfunction : ascp_rep_char

	always_comb
	begin
		logic rx_ok;
		logic [7:0] c;
		logic [7:0] uc;
		logic is_dig;
		logic is_term;
		logic hit;
		logic term;
		logic [7:0] ch;
		logic pb;
		logic [3:0] nb;
		rx_ok = 1'b0;
		term = 1'b0;
		c = q.rx_data;
		uc = (c >= CH_LA && c <= CH_LZ) ? (c & CASE_MASK) : c;
		is_dig = (c >= CH_0) && (c <= CH_9);
		is_term = (c == CH_DOLLAR) || (c == CH_STAR);
		hit = (q.node == 8'h00) || (q.node == my_node);
		nb = (q.par == PAR_NONE) ? NB_NOPAR : NB_PAR;
		ch = ascp_rep_char(q.rep, q.idx, q.val);
		pb = (q.par == PAR_ODD) ? ~^ch : ^ch;
		next_q = q;
		next_q.s1 = rxd;
		next_q.s2 = q.s1;
		next_q.s3 = q.s2;
		next_q.reg_we = 1'b0;
		next_q.reg_rd = 1'b0;
		next_q.txt_valid = 1'b0;
		// setting only moves between frames
		if (!q.rx_busy && !q.tx_busy)
			next_q.par = par_cfg;

		// receiver, sampling mid bit from the start edge
		if (!q.rx_busy)
		begin
			if (q.s3 && !q.s2)
			begin
				next_q.rx_busy = 1'b1;
				next_q.rx_div = DW'(BAUD_DIV / 2);
				next_q.rx_bit = 4'h0;
			end
		end
		else if (q.rx_div != '0)
			next_q.rx_div = q.rx_div - 1'b1;
		else
		begin
			next_q.rx_div = DW'(BAUD_DIV - 1);
			next_q.rx_bit = q.rx_bit + 4'h1;
			if (q.rx_bit == 4'h0)
			begin
				// start bit gone high again: a glitch, not a frame
				if (q.s2)
					next_q.rx_busy = 1'b0;
			end
			else if (q.rx_bit <= 4'h8)
				next_q.rx_data = {q.s2, q.rx_data[7:1]};
			else if (q.rx_bit == 4'h9 && q.par != PAR_NONE)
				next_q.rx_pb = q.s2;
			else
			begin
				next_q.rx_busy = 1'b0;
				rx_ok = q.s2 && (q.par == PAR_NONE
					|| ((^{q.rx_data, q.rx_pb}) == (q.par == PAR_ODD)));
			end
		end

		case (q.pst)
			P_IDLE:
			begin
				if (rx_ok && uc == CH_S)
				begin
					next_q.pst = P_NODE;
					next_q.node = 8'h00;
					next_q.addr = 16'h0000;
					next_q.has_addr = 1'b0;
					next_q.is_txt = 1'b0;
				end
			end
			P_NODE:
			begin
				if (rx_ok)
				begin
					if (is_dig)
						next_q.node = 8'(q.node * 8'd10 + {4'h0, c[3:0]});
					else if (uc == CH_R || uc == CH_W)
					begin
						next_q.is_wr = (uc == CH_W);
						next_q.pst = P_ADDR;
					end
					else
						next_q.pst = P_IDLE;
				end
			end
			P_ADDR:
			begin
				if (rx_ok)
				begin
					if (is_term)
						term = 1'b1;
					else if (is_dig)
					begin
						// a fresh address restarts here so reg_addr holds through the last reg_we
						next_q.addr = 16'((q.has_addr ? q.addr : 16'h0000) * 16'd10
							+ {12'h000, c[3:0]});
						next_q.has_addr = 1'b1;
					end
					else if (!q.has_addr && uc >= CH_A && uc <= CH_R)
					begin
						next_q.addr = {8'h00, uc - CH_AT};
						next_q.has_addr = 1'b1;
					end
					else if (!q.has_addr && uc == CH_T)
					begin
						next_q.addr = TXT_ADDR;
						next_q.has_addr = 1'b1;
						next_q.is_txt = 1'b1;
					end
					else if (q.is_wr)
					begin
						next_q.pst = P_DATA;
						next_q.mag = 32'h0000_0000;
						next_q.neg = 1'b0;
						next_q.has_dig = 1'b0;
					end
				end
			end
			P_DATA:
			begin
				if (rx_ok)
				begin
					if (is_term)
						term = 1'b1;
					else if (q.is_txt)
					begin
						next_q.txt_valid = hit;
						next_q.txt_char = c;
					end
					else if (is_dig)
					begin
						next_q.mag = 32'(q.mag * 32'd10 + {28'h0, c[3:0]});
						next_q.has_dig = 1'b1;
					end
					else if (c == CH_MINUS && !q.has_dig)
						next_q.neg = 1'b1;
					else if (q.has_dig)
					begin
						// separator after a value: commit and take the next address
						next_q.reg_we = hit;
						next_q.wd = q.neg ? (~q.mag + 32'h1) : q.mag;
						next_q.pst = P_ADDR;
						next_q.has_addr = 1'b0;
					end
				end
			end
			P_FETCH:
			begin
				next_q.val = reg_rdata;
				next_q.rep = !reg_ok ? REP_NUL : (q.is_wr ? REP_ACK : REP_VAL);
				next_q.pst = P_WAIT;
			end
			P_WAIT:
			begin
				if (q.dly == '0)
				begin
					next_q.pst = P_SEND;
					next_q.idx = 4'h0;
				end
				else
					next_q.dly = q.dly - 1'b1;
			end
			P_SEND:
			begin
				if (!q.tx_busy)
				begin
					if (q.idx == ascp_rep_len(q.rep))
						next_q.pst = P_IDLE;
					else
					begin
						next_q.tx_busy = 1'b1;
						next_q.tx_div = DW'(BAUD_DIV - 1);
						next_q.tx_bit = 4'h0;
						next_q.tx_sh = (q.par == PAR_NONE) ? {2'b11, ch, 1'b0}
							: {1'b1, pb, ch, 1'b0};
						next_q.idx = q.idx + 4'h1;
					end
				end
			end
			default:
				next_q.pst = P_IDLE;
		endcase

		if (term)
		begin
			next_q.star = (c == CH_STAR);
			next_q.dly = (c == CH_STAR) ? LW'(DLY_STAR) : LW'(DLY_DOL);
			next_q.wd = q.neg ? (~q.mag + 32'h1) : q.mag;
			if (!hit)
				next_q.pst = P_IDLE;
			else if (q.is_txt)
			begin
				next_q.rep = REP_ACK;
				next_q.pst = P_WAIT;
			end
			else if (!q.has_addr)
			begin
				next_q.val = disp_value;
				next_q.rep = q.is_wr ? REP_NUL : REP_VAL;
				next_q.pst = P_WAIT;
			end
			else
			begin
				next_q.reg_we = q.is_wr;
				next_q.reg_rd = !q.is_wr;
				next_q.pst = P_FETCH;
			end
		end

		// transmitter; ten or eleven bit periods a character
		if (q.tx_busy)
		begin
			if (q.tx_div != '0)
				next_q.tx_div = q.tx_div - 1'b1;
			else
			begin
				next_q.tx_div = DW'(BAUD_DIV - 1);
				next_q.tx_sh = {1'b1, q.tx_sh[10:1]};
				next_q.tx_bit = q.tx_bit + 4'h1;
				if (q.tx_bit == nb - 4'h1)
					next_q.tx_busy = 1'b0;
			end
		end
		next_q.txd = next_q.tx_busy ? next_q.tx_sh[0] : 1'b1;
		next_q.de = (next_q.pst == P_SEND);
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			q <= '0;
			q.s1 <= 1'b1;
			q.s2 <= 1'b1;
			q.s3 <= 1'b1;
			q.txd <= 1'b1;
		end
		else
			q <= next_q;
	end

	assign txd = q.txd;
	assign tx_en = q.de;
	assign reg_addr = q.addr;
	assign reg_wdata = q.wd;
	assign reg_we = q.reg_we;
	assign reg_rd = q.reg_rd;
	assign txt_valid = q.txt_valid;
	assign txt_char = q.txt_char;

	logic [3:0] nb_chk;
	assign nb_chk = (q.par == PAR_NONE) ? NB_NOPAR : NB_PAR;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	AST_IDLE_MARK: assert property (!q.tx_busy |-> txd)
		else $error("line not at mark while idle");
	AST_START_BIT: assert property ($rose(q.tx_busy) |=> !txd)
		else $error("frame did not open with a start bit");
	AST_BIT_HOLD: assert property (q.tx_busy && q.tx_div != '0 |=> $stable(q.tx_sh))
		else $error("tx bit changed inside its period");
	AST_PARITY: assert property ($rose(q.tx_busy) && q.par != PAR_NONE
		|-> (^q.tx_sh[9:1]) == (q.par == PAR_ODD))
		else $error("wrong tx parity");
	AST_STOP_LAST: assert property (q.tx_busy && q.tx_bit == nb_chk - 4'h1 |-> q.tx_sh[0])
		else $error("last bit of frame not a stop bit");
	AST_HALF_DUPLEX: assert property (q.pst inside {P_FETCH, P_WAIT, P_SEND}
		|=> !q.reg_we && !q.txt_valid)
		else $error("command acted on while replying");
	AST_DOL_DELAY: assert property ($rose(q.pst == P_WAIT) && !q.star
		|-> q.dly == LW'(DLY_DOL))
		else $error("dollar reply delay wrong");
	AST_STAR_DELAY: assert property ($rose(q.pst == P_WAIT) && q.star
		|-> q.dly == LW'(DLY_STAR))
		else $error("asterisk reply delay wrong");
	AST_LF_LAST: assert property ($rose(q.tx_busy) && q.idx == ascp_rep_len(q.rep)
		|-> q.tx_sh[8:1] == CH_LF)
		else $error("reply does not end with line feed");
	AST_READY: assert property ($fell(q.pst == P_SEND) |-> q.pst == P_IDLE && !q.tx_busy)
		else $error("not ready after reply");
	AST_NODE: assert property (q.reg_we || q.reg_rd |-> q.node == 8'h00 || q.node == my_node)
		else $error("foreign node acted on");
endmodule : ascp_port

// ==== ascp_host.sv ====
// host computer model on the serial line of the command port
`timescale 1ns/1ps
module ascp_host
	import ascp_pkg::*;
#(
	parameter int BD = 16
)(
	input wire logic sys_clk,
	output logic host_tx,
	input wire logic dev_tx,
	input wire logic [1:0] par_cfg
);
	logic [7:0] rxq[$];
	int cyc = 0;
	int t_rep = -1;
	int n_bad = 0;
	// idle at mark; driver stays at the stop bit level between strings
	initial host_tx = 1'b1;
	always @(posedge sys_clk) cyc <= cyc + 1;
	function automatic logic pbit(logic [7:0] c);
		return (par_cfg == PAR_ODD) ? ~^c : ^c;
	endfunction : pbit
	// callers wait for the reply before the next string, except t_busy, which sends during one
	task automatic send_str(string s);
		logic [10:0] f;
		@(negedge sys_clk);
		for (int k = 0; k < s.len(); k++)
		begin
			f = {1'b1, pbit(s[k]), s[k], 1'b0};
			if (par_cfg == PAR_NONE)
				f[9] = 1'b1;
			for (int i = 0; i < ((par_cfg == PAR_NONE) ? 10 : 11); i++)
			begin
				host_tx = f[i];
				repeat (BD) @(negedge sys_clk);
			end
		end
	endtask : send_str
	initial
	begin : rx_loop
		logic [7:0] c;
		forever
		begin
			@(negedge dev_tx);
			if (t_rep < 0)
				t_rep = cyc;
			// sample on falling edges, clear of the edge that moves txd
			repeat (BD / 2) @(negedge sys_clk);
			if (dev_tx !== 1'b0)
				n_bad++;
			for (int i = 0; i < 8; i++)
			begin
				repeat (BD) @(negedge sys_clk);
				c[i] = dev_tx;
			end
			if (par_cfg != PAR_NONE)
			begin
				repeat (BD) @(negedge sys_clk);
				if (dev_tx !== pbit(c))
					n_bad++;
			end
			repeat (BD) @(negedge sys_clk);
			if (dev_tx !== 1'b1)
				n_bad++;
			rxq.push_back(c);
		end
	end
endmodule : ascp_host

// ==== ascp_tb.sv ====
// self-checking testbench of the ascii serial command port
`timescale 1ns/1ps
module testbench;
	import ascp_pkg::*;
	localparam int BD = 16;
	localparam int DD = 200;
	localparam int DS = 40;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic rxd;
	logic txd;
	logic tx_en;
	logic reg_we;
	logic reg_rd;
	logic txt_valid;
	logic reg_ok = 1'b1;
	logic [1:0] par_cfg = PAR_NONE;
	logic [7:0] my_node = 8'h02;
	logic [7:0] txt_char;
	logic [7:0] txt_q[$];
	logic [31:0] disp_value = 32'h0000BEEF;
	logic [31:0] reg_rdata = 32'h1234ABCD;
	logic [31:0] reg_wdata;
	logic [31:0] w_seen = 32'h0;
	logic [15:0] reg_addr;
	logic [15:0] a_seen = 16'h0;
	logic [15:0] wa_q[$];
	logic [31:0] wd_q[$];
	int n_fail = 0;
	int tests_run = 0;
	int cycles = 0;
	ascp_port #(.BAUD_DIV(BD), .DLY_DOL(DD), .DLY_STAR(DS)) ascp_port_inst (
		.sys_clk(sys_clk), .nrst(nrst), .rxd(rxd), .txd(txd), .tx_en(tx_en),
		.par_cfg(par_cfg), .my_node(my_node), .disp_value(disp_value),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_ok(reg_ok), .txt_valid(txt_valid), .txt_char(txt_char)
	);
	ascp_host #(.BD(BD)) ascp_host_inst (
		.sys_clk(sys_clk), .host_tx(rxd), .dev_tx(txd), .par_cfg(par_cfg)
	);
	initial forever #10 sys_clk = ~sys_clk;
	always @(negedge sys_clk)
	begin
		if (reg_rd === 1'b1 || reg_we === 1'b1)
		begin
			a_seen <= reg_addr;
			w_seen <= reg_wdata;
		end
		if (reg_we === 1'b1)
		begin
			wa_q.push_back(reg_addr);
			wd_q.push_back(reg_wdata);
		end
		if (txt_valid === 1'b1)
			txt_q.push_back(txt_char);
		cycles++;
		if (cycles == 50000)
		begin
			n_fail++;
			finish_test();
		end
	end
	task automatic check(logic [31:0] got, logic [31:0] exp, string msg);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : check
	// kind 0 no reply, 1 body then cr lf, 2 nul cr lf
	task automatic cmd(string s, string body, int kind);
		int w;
		int tt;
		int n;
		int d;
		d = (s[s.len() - 1] == "$") ? DD : DS;
		n = (kind == 0) ? 0 : body.len() + kind + 1;
		ascp_host_inst.rxq.delete();
		ascp_host_inst.t_rep = -1;
		ascp_host_inst.send_str(s);
		tt = ascp_host_inst.cyc - BD / 2;
		w = 0;
		while (w < 3000 && (kind == 0 || ascp_host_inst.rxq.size() < n || tx_en !== 1'b0))
		begin
			@(negedge sys_clk);
			w++;
		end
		check(ascp_host_inst.rxq.size(), n, "reply length");
		if (kind != 0 && ascp_host_inst.rxq.size() == n)
		begin
			d = ascp_host_inst.t_rep - tt - d;
			check(d >= 0 && d <= DS, 1, "reply start");
			for (int i = 0; i < body.len(); i++)
				check(ascp_host_inst.rxq[i], body[i], "reply data");
			if (kind == 2)
				check(ascp_host_inst.rxq[0], CH_NUL, "null reply");
			check(ascp_host_inst.rxq[n - 2], CH_CR, "cr");
			check(ascp_host_inst.rxq[n - 1], CH_LF, "lf");
		end
	endtask : cmd
	task automatic t_read();
		cmd("SR3*", "1234ABCD", 1);
		check(a_seen, 32'h3, "read address");
		cmd("SR*", "0000BEEF", 1);
	endtask : t_read
	task automatic t_write();
		cmd("s2w5,-7$", "", 1);
		check(a_seen, 32'h5, "write address");
		check(w_seen, 32'hFFFFFFF9, "write data");
		wa_q.delete();
		wd_q.delete();
		cmd("SWB 9,4 12$", "", 1);
		check(wa_q.size(), 2, "multiple write count");
		if (wa_q.size() == 2)
		begin
			check(wa_q[0], 32'h2, "letter address");
			check(wd_q[0], 32'h9, "first value");
			check(wa_q[1], 32'h4, "second address");
			check(wd_q[1], 32'hC, "second value");
		end
	endtask : t_write
	task automatic t_refuse();
		cmd("S3R*", "", 0);
		cmd("SX3*", "", 0);
		reg_ok = 1'b0;
		cmd("SR9*", "", 2);
		reg_ok = 1'b1;
	endtask : t_refuse
	task automatic t_text();
		txt_q.delete();
		cmd("SWT ab$", "", 1);
		check(txt_q.size(), 2, "text count");
		if (txt_q.size() == 2)
			check({txt_q[0], txt_q[1]}, 32'h6162, "text chars");
	endtask : t_text
	task automatic t_parity();
		for (int p = 1; p < 3; p++)
		begin
			par_cfg = p[1:0];
			cmd("SR3*", "1234ABCD", 1);
		end
		par_cfg = PAR_NONE;
	endtask : t_parity
	task automatic t_busy();
		fork
			cmd("SR3*", "1234ABCD", 1);
			begin
				wait (tx_en === 1'b1);
				ascp_host_inst.send_str("SR5*");
			end
		join
		check(a_seen, 32'h3, "read while busy");
		cmd("SR6*", "1234ABCD", 1);
		check(a_seen, 32'h6, "next address");
	endtask : t_busy
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test
	initial
	begin
		repeat (16) @(negedge sys_clk);
		nrst = 1'b1;
		check(txd, 1'b1, "idle line");
		t_read();
		t_write();
		t_refuse();
		t_text();
		t_parity();
		t_busy();
		check(ascp_host_inst.n_bad, 0, "frame errors");
		finish_test();
	end
endmodule : testbench
